// ---- hw/fast_timer_pwm_defines.svh ----
// register offsets, field positions and fixed values of the fast pwm timer
`ifndef FAST_TIMER_PWM_DEFINES_SVH
`define FAST_TIMER_PWM_DEFINES_SVH

`define OFS_TIMER_CONTROL   4'h0
`define OFS_GENERAL_CONTROL 4'h1
`define OFS_COUNT           4'h2
`define OFS_COMPARE_A       4'h3
`define OFS_COMPARE_B       4'h4
`define OFS_TOP             4'h5
`define OFS_MASK            4'h6
`define OFS_FLAG            4'h7
`define OFS_CLOCK_CONTROL   4'h8

`define CTC_BIT      7
`define PWM_BIT      6
`define COM_HI       5
`define COM_LO       4
`define CS_HI        3
`define CS_LO        0
`define FOC_B_BIT    3
`define FOC_A_BIT    2
`define PSR_BIT      1
`define FLAG_A_BIT   6
`define FLAG_B_BIT   5
`define FLAG_OVF_BIT 2
`define FAST_EN_BIT  2

`define RESET_VALUE       8'h00
`define COMPAT_FUSE_CODE  4'h3
`define COMPAT_FAST_KHZ   25600
`define COUNT_WRAP_VALUE  8'hff
`define LONG_SHIFT_MAX    4'ha
`define COMPAT_FAST_LAST  4'h4
`define COMPAT_SYS_FIRST  4'h5

`endif

// ---- hw/fast_timer_pwm_pkg.sv ----
// types shared by the fast pwm timer
package fast_timer_pwm_pkg;

  typedef enum logic [1:0] {
    OUTMODE_OFF   = 2'h0,
    OUTMODE_PAIR  = 2'h1,
    OUTMODE_CLEAR = 2'h2,
    OUTMODE_SET   = 2'h3
  } outmode_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic true_level;
    logic inv_level;
    logic true_oe_n;
    logic inv_oe_n;
  } pin_pair_type;

  typedef struct packed {
    logic        ctc;
    logic        pwm_a;
    outmode_type mode_a;
    logic [3:0]  sel;
    logic        pwm_b;
    outmode_type mode_b;
    logic        fast_en;
    logic [7:0]  top;
  } ctl_type;

  typedef struct packed {
    ctl_type      ctl_sw;
    ctl_type      ctl_act;
    logic [7:0]   cmp_a_buf;
    logic [7:0]   cmp_b_buf;
    logic [7:0]   cmp_a;
    logic [7:0]   cmp_b;
    logic [7:0]   count;
    logic [7:0]   count_wval;
    logic         count_load;
    logic [7:0]   count_seen;
    logic [9:0]   pre_long;
    logic [2:0]   pre_short;
    logic         psr;
    logic         fast_prev;
    logic         ovf_evt;
    logic         a_evt;
    logic         b_evt;
    logic [2:0]   flags;
    logic [2:0]   flags_seen;
    logic [2:0]   mask;
    logic [2:0]   irq;
    logic [1:0]   force_req;
    logic [1:0]   force_now;
    pin_pair_type pin_a;
    pin_pair_type pin_b;
    logic [7:0]   rdata;
    logic [3:0]   fuses;
    logic         fuse_taken;
  } state_type;

endpackage

// ---- hw/fast_timer_pwm_unit.sv ----
// fast up-counting timer with two complementary pwm channels
`timescale 1ns/1ps
`include "fast_timer_pwm_defines.svh"
// Notes on behaviour
// - pwm mode: two 8-bit channels, true and inverted
// - pwm pair mode: true and inverted output both low for the tick at count 00
// - count 00 to top, overflow flag after delay
// - match acts per two-bit mode; 00 disconnects
// - mode 01: pair, clear/set at match, 01/00
// - mode 10: true cleared on match, set at 01
// - mode 11: true set on match, cleared at 01
// - pwm compare writes buffered until top reached
// - compare reads return the latest written value
// - compare at 00 or top holds outputs static
// - interrupt needs flag, enable and global enable
// - pwm period is top plus one ticks
// - codes 1..5 give fast clock /1../16
// - compatibility mode only with fuse code 0011
// - compatibility mode: short and long prescalers
// - compatibility clocking stays synchronous to core
// - compatibility selections: fast /1..8, system /1..1024
// - register writes reach counter one stage later
// - control reads immediate; count and flags delayed
// - compatibility normal mode: only compare A acts
// - overflow on ff wrap, and top wrap in pwm
// - top register is the counter maximum
// - either pwm bit; zero the tick after top
// - fast clock enable picks fast or system source
module fast_timer_pwm_unit (
  // clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // register port
  input  wire fast_timer_pwm_pkg::bus_req_type reg_req,
  output logic [7:0]                           reg_rdata,
  // fast clock, fuse strap, global interrupt enable
  input  wire logic                            fast_peripheral_clock,
  input  wire logic [3:0]                      clock_source_fuses,
  input  wire logic                            global_int_enable,
  // output pins
  output fast_timer_pwm_pkg::pin_pair_type     channel_a_output,
  output fast_timer_pwm_pkg::pin_pair_type     channel_b_output,
  // interrupt requests
  output logic                                 overflow_irq,
  output logic                                 compare_a_irq,
  output logic                                 compare_b_irq
);
  import fast_timer_pwm_pkg::*;

  state_type  st_reg;
  state_type  st_next;
  logic       adv;
  logic       top_wrap;
  logic       latch_a;
  logic [7:0] cnt_step;

  // one output pair, advanced by one counter step
  function automatic pin_pair_type pin_step(
    input pin_pair_type cur,
    input outmode_type  mode,
    input logic         pwm,
    input logic         act_en,
    input logic         step,
    input logic [7:0]   nxt,
    input logic [7:0]   cmp,
    input logic [7:0]   top,
    input logic         force_now
  );
    pin_pair_type p;
    p = cur;
    p.true_oe_n = (mode == OUTMODE_OFF) || !act_en;
    p.inv_oe_n  = !(pwm && act_en && mode == OUTMODE_PAIR);
    if (pwm) begin
      if (cmp == 8'h00 || cmp == top) begin
        // static level; a zero compare wins if top is zero too
        p.true_level = (cmp != 8'h00) ^ (mode == OUTMODE_SET);
        p.inv_level  = !p.true_level;
      end else if (step) begin
        if (nxt == cmp) begin
          p.true_level = (mode == OUTMODE_SET);
          p.inv_level  = 1'b1;
        end else begin
          if (nxt == 8'h01) begin
            p.true_level = (mode != OUTMODE_SET);
          end
          if (nxt == 8'h00) begin
            p.inv_level = 1'b0;
          end
        end
      end
    end else if ((step && nxt == cmp) || force_now) begin
      case (mode)
        OUTMODE_PAIR: begin
          p.true_level = !cur.true_level;
        end
        OUTMODE_CLEAR: begin
          p.true_level = 1'b0;
        end
        OUTMODE_SET: begin
          p.true_level = 1'b1;
        end
        default: begin
          p.true_level = cur.true_level;
        end
      endcase
    end
    return p;
  endfunction

  always_comb begin
    logic       compat;
    logic       pwm_any;
    logic       fast_edge;
    logic       use_fast;
    logic       src_edge;
    logic       tick;
    logic       wrap;
    logic       ovf_hit;
    logic       b_allowed;
    logic [3:0] k;
    logic [9:0] mask_long;
    logic [2:0] mask_short;
    logic [2:0] clr_f;
    logic [7:0] rd;
    ctl_type    c;
    st_next    = st_reg;
    c          = st_reg.ctl_act;
    clr_f      = 3'h0;
    rd         = 8'h00;
    compat     = 1'b0;
    pwm_any    = 1'b0;
    fast_edge  = 1'b0;
    use_fast   = 1'b0;
    src_edge   = 1'b0;
    tick       = 1'b0;
    wrap       = 1'b0;
    ovf_hit    = 1'b0;
    b_allowed  = 1'b0;
    k          = 4'h0;
    mask_long  = 10'h000;
    mask_short = 3'h0;
    // strap caught once, after reset is released
    if (!st_reg.fuse_taken) begin
      st_next.fuses      = clock_source_fuses;
      st_next.fuse_taken = 1'b1;
    end
    compat    = st_reg.fuses == `COMPAT_FUSE_CODE;
    pwm_any   = c.pwm_a | c.pwm_b;
    b_allowed = !(compat && !c.pwm_b);
    // fast clock is sampled, so every domain stays on sys_clk
    fast_edge         = fast_peripheral_clock & ~st_reg.fast_prev;
    st_next.fast_prev = fast_peripheral_clock;

    // prescaler and clock select
    use_fast = compat ? (c.sel <= `COMPAT_FAST_LAST) : c.fast_en;
    if (compat && !use_fast) begin
      k = c.sel - `COMPAT_SYS_FIRST;
    end else begin
      k = c.sel - 4'h1;
    end
    if (k > `LONG_SHIFT_MAX) begin
      k = `LONG_SHIFT_MAX;
    end
    mask_long  = 10'((11'h001 << k) - 11'h001);
    mask_short = 3'((4'h1 << k[1:0]) - 4'h1);
    src_edge   = use_fast ? fast_edge : 1'b1;
    if (compat && use_fast) begin
      tick = (c.sel != 4'h0) && fast_edge && ((st_reg.pre_short & mask_short) == mask_short);
    end else begin
      tick = (c.sel != 4'h0) && src_edge && ((st_reg.pre_long & mask_long) == mask_long);
    end
    if (st_reg.psr) begin
      st_next.pre_short = 3'h0;
      st_next.pre_long  = 10'h000;
      st_next.psr       = 1'b0;
    end else begin
      st_next.pre_short = 3'(st_reg.pre_short + {2'h0, fast_edge});
      st_next.pre_long  = 10'(st_reg.pre_long + {9'h000, compat | src_edge});
    end

    // counter; a pending software load takes the step
    adv      = tick && !st_reg.count_load;
    wrap     = (pwm_any && st_reg.count == c.top) || st_reg.count == `COUNT_WRAP_VALUE
               || (c.ctc && st_reg.count == st_reg.cmp_a);
    ovf_hit  = st_reg.count == `COUNT_WRAP_VALUE || (pwm_any && st_reg.count == c.top);
    cnt_step = wrap ? 8'h00 : 8'(st_reg.count + 8'h01);
    top_wrap = adv && pwm_any && st_reg.count == c.top;
    if (st_reg.count_load) begin
      st_next.count      = st_reg.count_wval;
      st_next.count_load = 1'b0;
    end else if (tick) begin
      st_next.count = cnt_step;
    end
    st_next.ovf_evt = adv && ovf_hit;
    st_next.a_evt   = adv && cnt_step == st_reg.cmp_a;
    st_next.b_evt   = adv && b_allowed && cnt_step == st_reg.cmp_b;

    // compare buffers move in only at top while in pwm mode
    latch_a = c.pwm_a ? top_wrap : 1'b1;
    if (latch_a) begin
      st_next.cmp_a = st_reg.cmp_a_buf;
    end
    if (c.pwm_b ? top_wrap : 1'b1) begin
      st_next.cmp_b = st_reg.cmp_b_buf;
    end

    // output pairs; in pwm pair mode true and inverted are both low for the tick at count 00
    st_next.pin_a = pin_step(st_reg.pin_a, c.mode_a, c.pwm_a, 1'b1, adv, cnt_step,
                             st_reg.cmp_a, c.top, st_reg.force_now[0]);
    st_next.pin_b = pin_step(st_reg.pin_b, c.mode_b, c.pwm_b, b_allowed, adv, cnt_step,
                             st_reg.cmp_b, c.top, st_reg.force_now[1]);
    // force waits a stage so a mode written with it is already active
    st_next.force_now = st_reg.force_req & ~{c.pwm_b, c.pwm_a};
    st_next.force_req = 2'h0;

    // control passes one sync stage before the counter sees it
    st_next.ctl_act = st_reg.ctl_sw;

    // bus writes
    if (reg_req.wr) begin
      if (reg_req.addr == `OFS_TIMER_CONTROL) begin
        st_next.ctl_sw.ctc    = reg_req.wdata[`CTC_BIT];
        st_next.ctl_sw.pwm_a  = reg_req.wdata[`PWM_BIT];
        st_next.ctl_sw.mode_a = outmode_type'(reg_req.wdata[`COM_HI:`COM_LO]);
        st_next.ctl_sw.sel    = reg_req.wdata[`CS_HI:`CS_LO];
      end else if (reg_req.addr == `OFS_GENERAL_CONTROL) begin
        st_next.ctl_sw.pwm_b  = reg_req.wdata[`PWM_BIT];
        st_next.ctl_sw.mode_b = outmode_type'(reg_req.wdata[`COM_HI:`COM_LO]);
        st_next.force_req     = {reg_req.wdata[`FOC_B_BIT], reg_req.wdata[`FOC_A_BIT]};
        st_next.psr           = st_reg.psr | reg_req.wdata[`PSR_BIT];
      end else if (reg_req.addr == `OFS_COUNT) begin
        st_next.count_wval = reg_req.wdata;
        st_next.count_load = 1'b1;
      end else if (reg_req.addr == `OFS_COMPARE_A) begin
        st_next.cmp_a_buf = reg_req.wdata;
      end else if (reg_req.addr == `OFS_COMPARE_B) begin
        st_next.cmp_b_buf = reg_req.wdata;
      end else if (reg_req.addr == `OFS_TOP) begin
        st_next.ctl_sw.top = reg_req.wdata;
      end else if (reg_req.addr == `OFS_MASK) begin
        st_next.mask = {reg_req.wdata[`FLAG_A_BIT], reg_req.wdata[`FLAG_B_BIT],
                        reg_req.wdata[`FLAG_OVF_BIT]};
      end else if (reg_req.addr == `OFS_FLAG) begin
        clr_f = {reg_req.wdata[`FLAG_A_BIT], reg_req.wdata[`FLAG_B_BIT],
                 reg_req.wdata[`FLAG_OVF_BIT]};
      end else if (reg_req.addr == `OFS_CLOCK_CONTROL) begin
        st_next.ctl_sw.fast_en = reg_req.wdata[`FAST_EN_BIT];
      end
    end

    // flags: a new event beats a clear in the same cycle
    st_next.flags      = (st_reg.flags & ~clr_f)
                         | {st_reg.a_evt, st_reg.b_evt, st_reg.ovf_evt};
    st_next.flags_seen = st_reg.flags;
    st_next.count_seen = st_reg.count;
    st_next.irq        = st_next.flags & st_reg.mask & {3{global_int_enable}};

    // reads answer in the next cycle only
    if (reg_req.rd) begin
      if (reg_req.addr == `OFS_TIMER_CONTROL) begin
        rd = {st_reg.ctl_sw.ctc, st_reg.ctl_sw.pwm_a, st_reg.ctl_sw.mode_a, st_reg.ctl_sw.sel};
      end else if (reg_req.addr == `OFS_GENERAL_CONTROL) begin
        rd = {1'b0, st_reg.ctl_sw.pwm_b, st_reg.ctl_sw.mode_b, 4'h0};
      end else if (reg_req.addr == `OFS_COUNT) begin
        rd = st_reg.count_seen;
      end else if (reg_req.addr == `OFS_COMPARE_A) begin
        rd = st_reg.cmp_a_buf;
      end else if (reg_req.addr == `OFS_COMPARE_B) begin
        rd = st_reg.cmp_b_buf;
      end else if (reg_req.addr == `OFS_TOP) begin
        rd = st_reg.ctl_sw.top;
      end else if (reg_req.addr == `OFS_MASK) begin
        rd[`FLAG_A_BIT]   = st_reg.mask[2];
        rd[`FLAG_B_BIT]   = st_reg.mask[1];
        rd[`FLAG_OVF_BIT] = st_reg.mask[0];
      end else if (reg_req.addr == `OFS_FLAG) begin
        rd[`FLAG_A_BIT]   = st_reg.flags_seen[2];
        rd[`FLAG_B_BIT]   = st_reg.flags_seen[1];
        rd[`FLAG_OVF_BIT] = st_reg.flags_seen[0];
      end else if (reg_req.addr == `OFS_CLOCK_CONTROL) begin
        rd[`FAST_EN_BIT] = st_reg.ctl_sw.fast_en;
      end else begin
        rd = `RESET_VALUE;
      end
    end
    st_next.rdata = rd;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata        = st_reg.rdata;
  assign channel_a_output = st_reg.pin_a;
  assign channel_b_output = st_reg.pin_b;
  assign overflow_irq     = st_reg.irq[0];
  assign compare_b_irq    = st_reg.irq[1];
  assign compare_a_irq    = st_reg.irq[2];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_top_wrap_zero: assert property (top_wrap |=> st_reg.count == 8'h00)
    else $error("counter did not return to zero after top");
  chk_overflow_flag_set: assert property (st_reg.ovf_evt |=> st_reg.flags[0])
    else $error("overflow event did not set its flag");
  chk_buffer_held: assert property (st_reg.ctl_act.pwm_a && !latch_a |=> $stable(st_reg.cmp_a))
    else $error("compare A changed away from top in pwm mode");
  chk_compare_readback: assert property (reg_req.rd && reg_req.addr == `OFS_COMPARE_A
    |=> reg_rdata == $past(st_reg.cmp_a_buf))
    else $error("compare A read did not return latest write");
  chk_mode_off_pins: assert property (st_reg.ctl_act.mode_a == OUTMODE_OFF
    |=> channel_a_output.true_oe_n && channel_a_output.inv_oe_n)
    else $error("channel A driven while disconnected");
  chk_static_zero: assert property (st_reg.ctl_act.pwm_a && st_reg.ctl_act.mode_a == OUTMODE_CLEAR
    && st_reg.cmp_a == 8'h00 |=> !channel_a_output.true_level)
    else $error("zero compare did not hold channel A low");
  chk_irq_gate: assert property ($rose(overflow_irq) |-> st_reg.flags[0] && $past(global_int_enable))
    else $error("overflow interrupt without flag or global enable");
  chk_no_load_match: assert property (st_reg.count_load |=> !st_reg.a_evt && !st_reg.b_evt)
    else $error("software count load produced a match");
  chk_stopped_count: assert property (st_reg.ctl_act.sel == 4'h0 && !st_reg.count_load
    |=> $stable(st_reg.count))
    else $error("counter moved while stopped");
  chk_ctl_sync: assert property (reg_req.wr && reg_req.addr == `OFS_TOP
    |=> ##1 st_reg.ctl_act.top == $past(reg_req.wdata, 2))
    else $error("top write not active two cycles later");
endmodule

// ---- tb/pwm_load_model.sv ----
// load on the timer pins: resolves pin levels and counts high cycles per pin
`timescale 1ns/1ps
module pwm_load_model (
  // clock and measurement control
  input  wire logic                             sys_clk,
  input  wire logic                             meas_clear,
  // pins from the timer
  input  wire fast_timer_pwm_pkg::pin_pair_type channel_a_output,
  input  wire fast_timer_pwm_pkg::pin_pair_type channel_b_output,
  // resolved levels, enables and high-time counts
  output logic [3:0]                            pin_level,
  output logic [3:0]                            pin_oe_n,
  output logic [3:0][15:0]                      high_cnt
);
  import fast_timer_pwm_pkg::*;
  logic [3:0] drive;

  assign drive = {channel_b_output.inv_level, channel_b_output.true_level,
                  channel_a_output.inv_level, channel_a_output.true_level};
  assign pin_oe_n = {channel_b_output.inv_oe_n, channel_b_output.true_oe_n,
                     channel_a_output.inv_oe_n, channel_a_output.true_oe_n};
  // a released pin falls to the load's pull-down, never keeps its last level
  assign pin_level = drive & ~pin_oe_n;

  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (meas_clear) begin
        high_cnt[i] <= 16'h0;
      end else begin
        high_cnt[i] <= high_cnt[i] + 16'(pin_level[i]);
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the fast pwm timer
`timescale 1ns/1ps
module tb_top;
  import fast_timer_pwm_pkg::*;
  logic             sys_clk;
  logic             sys_rst;
  bus_req_type      reg_req;
  logic [7:0]       reg_rdata;
  logic [1:0]       fcnt = 2'h0;
  logic [3:0]       fuses;
  logic             gie;
  pin_pair_type     pa;
  pin_pair_type     pb;
  logic             ovf_irq;
  logic             cmpa_irq;
  logic             cmpb_irq;
  logic             meas_clear;
  logic [3:0]       pin_level;
  logic [3:0]       pin_oe_n;
  logic [3:0][15:0] high_cnt;
  logic [3:0][15:0] hc;
  logic [3:0]       oe;
  int               mismatches = 0;
  int               checked = 0;
  int               p;
  int               t_hi [3][3] = '{'{0, 3, 10}, '{0, 3, 10}, '{10, 7, 0}};
  int               i_hi [3] = '{10, 6, 0};
  logic [7:0]       cmpv [3] = '{8'h00, 8'h04, 8'h09};
  logic [3:0]       ra [5] = '{4'h0, 4'h5, 4'h9, 4'h6, 4'h1};
  logic [7:0]       rv [5] = '{8'h80, 8'ha5, 8'h5a, 8'hff, 8'h0e};
  logic [7:0]       re [5] = '{8'h80, 8'ha5, 8'h00, 8'h64, 8'h00};

  fast_timer_pwm_unit dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .fast_peripheral_clock(fcnt[1]), .clock_source_fuses(fuses), .global_int_enable(gie),
    .channel_a_output(pa), .channel_b_output(pb), .overflow_irq(ovf_irq),
    .compare_a_irq(cmpa_irq), .compare_b_irq(cmpb_irq)
  );
  pwm_load_model load (
    .sys_clk(sys_clk), .meas_clear(meas_clear), .channel_a_output(pa), .channel_b_output(pb),
    .pin_level(pin_level), .pin_oe_n(pin_oe_n), .high_cnt(high_cnt)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // fast clock at a quarter of the system rate, well under the edge detector's limit
  always @(posedge sys_clk) fcnt <= fcnt + 2'h1;

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access, then one idle cycle so the strobe is never re-driven in the same step
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 q = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(16'(q), 16'(e));
  endtask

  task automatic meas(input int n);
    meas_clear <= 1'b1;
    @(posedge sys_clk);
    meas_clear <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1 hc = high_cnt;
    oe = pin_oe_n;
    @(posedge sys_clk);
  endtask

  // cycles between two rising edges of channel A's true pin
  task automatic get_period(output int pr);
    int n;
    int e;
    logic prv;
    n = 0;
    e = 0;
    pr = 0;
    prv = 1'b1;
    while (e < 2 && n < 4000) begin
      @(posedge sys_clk);
      n++;
      if (e == 1) pr++;
      if (pin_level[0] === 1'b1 && prv === 1'b0) e++;
      prv = pin_level[0];
    end
  endtask

  task automatic do_reset(input logic [3:0] f);
    sys_rst <= 1'b1;
    fuses <= f;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    reg_req = '0;
    fuses = 4'h0;
    gie = 1'b0;
    meas_clear = 1'b0;
    do_reset(4'h0);
    chk(16'(pin_oe_n), 16'h000f);
    for (int a = 0; a < 10; a++) chk_rd(4'(a), 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rv[i]);
      chk_rd(ra[i], re[i]);
    end
    wr(4'h6, 8'h00);
    // stopped timer: a count write onto the compare value must not match
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h33);
    wr(4'h7, 8'hff);
    wr(4'h2, 8'h33);
    repeat (5) @(posedge sys_clk);
    chk_rd(4'h2, 8'h33);
    chk_rd(4'h7, 8'h00);
    wr(4'h0, 8'h01);
    repeat (10) @(posedge sys_clk);
    chk_rd(4'h7, 8'h00);
    wr(4'h2, 8'hf0);
    repeat (30) @(posedge sys_clk);
    // compare B still holds zero, so the ff wrap matches it too
    chk_rd(4'h7, 8'h24);
    repeat (50) @(posedge sys_clk);
    chk_rd(4'h7, 8'h64);
    wr(4'h6, 8'h04);
    repeat (4) @(posedge sys_clk);
    chk(16'(ovf_irq), 16'h0);
    gie <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(16'(ovf_irq), 16'h1);
    wr(4'h6, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk(16'(ovf_irq), 16'h0);
    chk(16'(cmpa_irq), 16'h1);
    chk(16'(cmpb_irq), 16'h0);
    wr(4'h7, 8'hff);
    repeat (4) @(posedge sys_clk);
    chk(16'(cmpa_irq), 16'h0);
    // pwm with top 9: modes 01 to 11 and compare values 00, 04, 09 on both channels
    wr(4'h5, 8'h09);
    for (int ch = 0; ch < 2; ch++) begin
      if (ch == 1) wr(4'h0, 8'h01);
      // restart low so pwm starts before the count passes top
      wr(4'h2, 8'h00);
      for (int m = 1; m < 4; m++) begin
        for (int c = 0; c < 3; c++) begin
          wr(4'(3 + ch), cmpv[c]);
          if (ch == 0) wr(4'h0, {2'b01, 2'(m), 4'h1});
          else wr(4'h1, {2'b01, 2'(m), 4'h0});
          repeat (30) @(posedge sys_clk);
          meas(20);
          chk(hc[2 * ch], 16'(2 * t_hi[m - 1][c]));
          if (m == 1) chk(hc[2 * ch + 1], 16'(2 * i_hi[c]));
          chk(16'(oe[2 * ch +: 2]), (m == 1) ? 16'h0 : 16'h2);
        end
      end
    end
    wr(4'h1, 8'h00);
    // buffered compare reads back the newest value, then takes effect
    wr(4'h0, 8'h61);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h07);
    chk_rd(4'h3, 8'h07);
    repeat (30) @(posedge sys_clk);
    meas(20);
    chk(hc[0], 16'd12);
    wr(4'h3, 8'h04);
    // fast clock source with divider codes 1 to 5
    wr(4'h8, 8'h04);
    for (int s = 1; s < 6; s++) begin
      wr(4'h0, {4'b0110, 4'(s)});
      get_period(p);
      get_period(p);
      chk(16'(p), 16'(40 << (s - 1)));
    end
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h62);
    get_period(p);
    get_period(p);
    chk(16'(p), 16'd20);
    // compatibility strap: fast /8, then system clock /1 and /2
    do_reset(4'h3);
    wr(4'h5, 8'h09);
    wr(4'h3, 8'h04);
    for (int s = 4; s < 7; s++) begin
      wr(4'h0, {4'b0110, 4'(s)});
      get_period(p);
      get_period(p);
      chk(16'(p), (s == 4) ? 16'd320 : 16'(10 << (s - 5)));
    end
    end_of_test();
  end
endmodule
